/* File: hw/rac_pkg.sv */
// Constants, types and register map of the record acquisition control block
// Summary of operation
// - Record length at least 256, multiple of 16
// - Pretrigger samples first, then trigger detection enabled
// - Single channel pretrigger 0 to 4080, step 16
// - Dual channel pretrigger 0 to 2032, step 16
// - Session pretrigger depth applies to every record
// - Record count at least 1, no upper bound
// - Capture event lamp on during post-trigger capture
// - Armed lamp on while armed for capture
// - Reference source lamp on for internal clock
// - Base clock lamp toggles while base clock alive
// - Oscillator failure lamp on when oscillator stopped
// - Host bus lamp on once link negotiated
// - Setup done lamp on after configuration, stays on
// - Outside event input triggers only, never digitized
// - Sampling path never clocked above 20 MS/s
// - Spare port: trigger out, pacer, dout, trigger enable, din
// - Per channel AC or DC coupling setting
// - Bracket identification lamp under software control
// - Power fault lamp shows supply problems
package rac_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REC_LEN = 8'h08;
  localparam logic [7:0] REG_PRETRIG = 8'h0C;
  localparam logic [7:0] REG_REC_COUNT = 8'h10;
  localparam logic [7:0] REG_SPARE_IO = 8'h14;
  localparam logic [7:0] REG_PACER_DIV = 8'h18;
  localparam logic [7:0] REG_RECS_DONE = 8'h1C;

  // Control register fields
  localparam int unsigned CTRL_ARM = 0;
  localparam int unsigned CTRL_ABORT = 1;
  localparam int unsigned CTRL_DUAL = 2;
  localparam int unsigned CTRL_EXT_CLK = 3;
  localparam int unsigned CTRL_CAPTURE_EVENT_LAMP_SRC_LO = 4;
  localparam int unsigned CTRL_AC_LO = 6;
  localparam int unsigned CTRL_IDENT = 8;
  localparam int unsigned CTRL_ERR_CLR = 9;
  localparam logic [9:0] CTRL_RESET = 10'h004;

  // Acquisition limits
  localparam int unsigned REC_LEN_MIN = 256;
  localparam int unsigned GRAIN = 16;
  localparam int unsigned PRE_MAX_SINGLE = 4080;
  localparam int unsigned PRE_MAX_DUAL = 2040;
  localparam int unsigned REC_COUNT_MIN = 1;

  // Internal pacer: system clock is the fastest legal converter rate
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned ADC_MAX_SPS = 20_000_000;
  localparam int unsigned PACER_DIV_MIN = (SYS_CLK_HZ + ADC_MAX_SPS - 1) / ADC_MAX_SPS;
  localparam logic [15:0] PACER_DIV_RESET = 16'h0014;

  // Base clock heartbeat watchdog
  localparam int unsigned BASE_HB_TIMEOUT_CYC = 1024;

  typedef enum logic [1:0] {
    RAC_CAPTURE_EVENT_LAMP_CHAN_ONE = 2'h0,
    RAC_CAPTURE_EVENT_LAMP_CHAN_TWO = 2'h1,
    RAC_CAPTURE_EVENT_LAMP_OUTSIDE = 2'h2
  } rac_capture_event_lamp_src_e;

  typedef enum logic [2:0] {
    RAC_SPARE_CAPTURE_EVENT_LAMP_OUT = 3'h0,
    RAC_SPARE_PACER_OUT = 3'h1,
    RAC_SPARE_DIG_OUT = 3'h2,
    RAC_SPARE_CAPTURE_EVENT_LAMP_EN_IN = 3'h3,
    RAC_SPARE_DIG_IN = 3'h4
  } rac_spare_mode_e;

  typedef enum logic [1:0] {
    RAC_IDLE = 2'b00,
    RAC_PRE = 2'b01,
    RAC_WAIT_CAPTURE_EVENT_LAMP = 2'b11,
    RAC_POST = 2'b10
  } rac_state_e;

  typedef struct packed {
    logic armed_lamp;
    logic capture_event_lamp;
    logic reference_source_lamp;
    logic base_clock_lamp;
    logic oscillator_failure_lamp;
    logic host_bus_up_lamp;
    logic setup_done_lamp;
    logic ident_lamp;
    logic [1:0] power_fault_lamp;
  } rac_lamps_s;

  typedef struct packed {
    logic osc_lost;
    logic link_up;
    logic config_done;
    logic [1:0] power_fault;
    logic base_heartbeat;
  } rac_board_s;

endpackage

/* File: hw/rac_top.sv */
// Record acquisition control with Avalon-MM register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module rac_top #(
  parameter int unsigned LEN_W = 24,
  parameter int unsigned CNT_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [rac_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [rac_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [rac_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_outside_sample_clock_input,
  input wire logic i_chan_one_capture_event_lamp,
  input wire logic i_chan_two_capture_event_lamp,
  input wire logic i_outside_event_input,
  input wire logic i_spare_io_in,
  input wire rac_pkg::rac_board_s i_board,
  output logic o_spare_io_out,
  output logic o_spare_io_oe,
  output logic o_adc_sample_en,
  output logic o_record_sample,
  output logic o_record_end,
  output logic [1:0] o_ac_coupling,
  output rac_pkg::rac_lamps_s o_lamps
);
  import rac_pkg::*;

  localparam int unsigned PIN_N = 5;

  // Configuration registers
  logic [9:0] ctrl;
  logic [LEN_W-1:0] rec_len;
  logic [11:0] pretrig;
  logic [CNT_W-1:0] rec_count;
  logic [2:0] spare_mode;
  logic spare_dout;
  logic [15:0] pacer_div;
  logic cfg_err;

  // Session shadow copies, frozen at arm
  logic [LEN_W-1:0] s_post_len;
  logic [11:0] s_pretrig;
  logic [CNT_W-1:0] s_rec_count;
  logic [1:0] s_capture_event_lamp_src;

  rac_state_e state;
  rac_state_e next_state;
  logic [LEN_W-1:0] smp_cnt;
  logic [CNT_W-1:0] recs_done;

  // Pin synchronisers: ff1 feeds only ff2
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_ff1;
  logic [PIN_N-1:0] pin_ff2;
  logic [PIN_N-1:0] pin_d;
  rac_board_s brd_ff1;
  rac_board_s brd_ff2;
  logic hb_d;

  assign pin_raw = {i_spare_io_in, i_outside_event_input, i_chan_two_capture_event_lamp, i_chan_one_capture_event_lamp,
                    i_outside_sample_clock_input};

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      pin_ff1 <= '0;
      pin_ff2 <= '0;
      pin_d <= '0;
      brd_ff1 <= '0;
      brd_ff2 <= '0;
      hb_d <= 1'b0;
    end
    else
    begin
      pin_ff1 <= pin_raw;
      pin_ff2 <= pin_ff1;
      pin_d <= pin_ff2;
      brd_ff1 <= i_board;
      brd_ff2 <= brd_ff1;
      hb_d <= brd_ff2.base_heartbeat;
    end
  end

  wire [PIN_N-1:0] pin_rise = pin_ff2 & ~pin_d;
  wire ext_clk_tick = pin_rise[0];
  wire spare_in_s = pin_ff2[4];

  // Validity check of a session setting
  function automatic logic cfg_valid(input logic [LEN_W-1:0] len, input logic [11:0] pre,
                                     input logic [CNT_W-1:0] cnt, input logic dual);
    logic [11:0] pre_max;
    pre_max = dual ? 12'(PRE_MAX_DUAL) : 12'(PRE_MAX_SINGLE);
    cfg_valid = (len >= LEN_W'(REC_LEN_MIN)) && (len[3:0] == 4'h0)
             && (pre[3:0] == 4'h0) && (pre <= pre_max)
             && (LEN_W'(pre) < len) // pretrigger must leave post samples
             && (cnt >= CNT_W'(REC_COUNT_MIN));
  endfunction

  // Avalon slave: answer one cycle after the request is seen
  wire bus_req = i_avs_read | i_avs_write;
  wire bus_fire = bus_req & ~o_avs_waitrequest;
  wire wr_fire = i_avs_write & bus_fire;
  wire [31:0] wdata = i_avs_writedata;
  wire lane_ok = &i_avs_byteenable;
  wire wr_ctrl = wr_fire & lane_ok & (i_avs_address == REG_CTRL);
  wire arm_req = wr_ctrl & wdata[CTRL_ARM];
  wire abort_req = wr_ctrl & wdata[CTRL_ABORT];
  wire idle = (state == RAC_IDLE);
  wire new_dual = wdata[CTRL_DUAL];
  wire arm_ok = arm_req & idle & cfg_valid(rec_len, pretrig, rec_count, new_dual);
  wire arm_bad = arm_req & idle & ~arm_ok;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      ctrl <= CTRL_RESET;
      rec_len <= LEN_W'(REC_LEN_MIN);
      pretrig <= '0;
      rec_count <= CNT_W'(REC_COUNT_MIN);
      spare_mode <= RAC_SPARE_DIG_IN;
      spare_dout <= 1'b0;
      pacer_div <= PACER_DIV_RESET;
    end
    else if (wr_fire && lane_ok)
    begin
      unique case (i_avs_address)
        REG_CTRL:
        begin
          // Steering bits frozen while a session runs
          ctrl[CTRL_IDENT] <= wdata[CTRL_IDENT];
          ctrl[CTRL_AC_LO+:2] <= wdata[CTRL_AC_LO+:2];
          if (idle)
            ctrl[CTRL_CAPTURE_EVENT_LAMP_SRC_LO+:2] <= wdata[CTRL_CAPTURE_EVENT_LAMP_SRC_LO+:2];
          if (idle)
            ctrl[CTRL_EXT_CLK] <= wdata[CTRL_EXT_CLK];
          if (idle)
            ctrl[CTRL_DUAL] <= wdata[CTRL_DUAL];
        end
        REG_REC_LEN: if (idle) rec_len <= wdata[LEN_W-1:0];
        REG_PRETRIG: if (idle) pretrig <= wdata[11:0];
        REG_REC_COUNT: if (idle) rec_count <= wdata[CNT_W-1:0];
        REG_SPARE_IO:
        begin
          spare_mode <= wdata[2:0];
          spare_dout <= wdata[4];
        end
        REG_PACER_DIV:
        begin
          if (wdata[15:0] >= 16'(PACER_DIV_MIN))
            pacer_div <= wdata[15:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Error flag: a failed arm wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      cfg_err <= 1'b0;
    else if (arm_bad)
      cfg_err <= 1'b1;
    else if (wr_ctrl && wdata[CTRL_ERR_CLR])
      cfg_err <= 1'b0;
  end

  // Read mux, unmapped addresses read zero
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = '0;
    unique case (i_avs_address)
      REG_CTRL: rd_val[9:0] = {1'b0, ctrl[8:0]};
      REG_STATUS: rd_val[3:0] = {cfg_err, ~idle, state};
      REG_REC_LEN: rd_val[LEN_W-1:0] = rec_len;
      REG_PRETRIG: rd_val[11:0] = pretrig;
      REG_REC_COUNT: rd_val[CNT_W-1:0] = rec_count;
      REG_SPARE_IO: rd_val[5:0] = {spare_in_s, spare_dout, 1'b0, spare_mode};
      REG_PACER_DIV: rd_val[15:0] = pacer_div;
      REG_RECS_DONE: rd_val[CNT_W-1:0] = recs_done;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end
    else
    begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rd_val;
    end
  end

  // Internal pacer, never faster than the converter limit
  logic [15:0] pacer_cnt;
  logic pacer_lvl;
  wire pacer_tick = (pacer_cnt == 16'h0001) || (pacer_cnt == 16'h0000);
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      pacer_cnt <= PACER_DIV_RESET;
      pacer_lvl <= 1'b0;
    end
    else if (pacer_tick)
    begin
      pacer_cnt <= pacer_div;
      pacer_lvl <= ~pacer_lvl;
    end
    else
      pacer_cnt <= pacer_cnt - 16'h0001;
  end

  // External clock ticks need at most half the system rate to be seen
  wire ext_sel = ctrl[CTRL_EXT_CLK];
  wire sample_tick = ext_sel ? ext_clk_tick : pacer_tick;

  // Trigger source; the outside event never reaches the sample path
  wire [1:0] capture_event_lamp_src = idle ? ctrl[CTRL_CAPTURE_EVENT_LAMP_SRC_LO+:2] : s_capture_event_lamp_src;
  logic capture_event_lamp_hit;
  always_comb
  begin
    unique case (capture_event_lamp_src)
      RAC_CAPTURE_EVENT_LAMP_CHAN_ONE: capture_event_lamp_hit = pin_rise[1];
      RAC_CAPTURE_EVENT_LAMP_CHAN_TWO: capture_event_lamp_hit = pin_rise[2];
      RAC_CAPTURE_EVENT_LAMP_OUTSIDE: capture_event_lamp_hit = pin_rise[3];
      default: capture_event_lamp_hit = 1'b0;
    endcase
  end
  wire capture_event_lamp_gate = (spare_mode != RAC_SPARE_CAPTURE_EVENT_LAMP_EN_IN) || spare_in_s;
  wire capture_event_lamp_take = (state == RAC_WAIT_CAPTURE_EVENT_LAMP) && capture_event_lamp_hit && capture_event_lamp_gate;

  wire pre_done = (smp_cnt >= LEN_W'(s_pretrig));
  wire post_done = sample_tick && (smp_cnt == s_post_len - LEN_W'(1));
  wire last_rec = (recs_done + CNT_W'(1) == s_rec_count);

  always_comb
  begin
    next_state = state;
    unique case (state)
      RAC_IDLE: if (arm_ok) next_state = RAC_PRE;
      RAC_PRE: if (pre_done) next_state = RAC_WAIT_CAPTURE_EVENT_LAMP;
      RAC_WAIT_CAPTURE_EVENT_LAMP: if (capture_event_lamp_take) next_state = RAC_POST;
      RAC_POST: if (post_done) next_state = last_rec ? RAC_IDLE : RAC_PRE;
    endcase
    if (abort_req)
      next_state = RAC_IDLE;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      state <= RAC_IDLE;
    else
      state <= next_state;
  end

  // Sample counter restarts at each phase boundary
  wire phase_chg = (next_state != state);
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      smp_cnt <= '0;
    else if (phase_chg)
      smp_cnt <= '0;
    else if (sample_tick && (state == RAC_PRE || state == RAC_POST))
      smp_cnt <= smp_cnt + LEN_W'(1);
  end

  // Session copies; counter wide enough that no count limit applies
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      s_post_len <= LEN_W'(REC_LEN_MIN);
      s_pretrig <= '0;
      s_rec_count <= CNT_W'(REC_COUNT_MIN);
      s_capture_event_lamp_src <= RAC_CAPTURE_EVENT_LAMP_CHAN_ONE;
      recs_done <= '0;
    end
    else if (arm_ok)
    begin
      s_post_len <= rec_len - LEN_W'(pretrig);
      s_pretrig <= pretrig;
      s_rec_count <= rec_count;
      s_capture_event_lamp_src <= wdata[CTRL_CAPTURE_EVENT_LAMP_SRC_LO+:2];
      recs_done <= '0;
    end
    else if (state == RAC_POST && post_done)
      recs_done <= recs_done + CNT_W'(1);
  end

  // Base clock watchdog: lamp follows heartbeat only while it moves
  logic [10:0] hb_idle;
  wire hb_edge = brd_ff2.base_heartbeat ^ hb_d;
  wire hb_alive = (hb_idle < 11'(BASE_HB_TIMEOUT_CYC));
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      hb_idle <= 11'(BASE_HB_TIMEOUT_CYC);
    else if (hb_edge)
      hb_idle <= '0;
    else if (hb_alive)
      hb_idle <= hb_idle + 11'h001;
  end

  // Outputs
  // Tick in the cycle that ends pretrigger belongs to no record
  wire capturing = ((state == RAC_PRE) && !pre_done) || (state == RAC_POST);
  logic setup_seen;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      setup_seen <= 1'b0;
      o_lamps <= '0;
      o_spare_io_out <= 1'b0;
      o_spare_io_oe <= 1'b0;
      o_adc_sample_en <= 1'b0;
      o_record_sample <= 1'b0;
      o_record_end <= 1'b0;
      o_ac_coupling <= '0;
    end
    else
    begin
      setup_seen <= setup_seen | brd_ff2.config_done;
      o_lamps.armed_lamp <= ~idle;
      o_lamps.capture_event_lamp <= (state == RAC_POST);
      o_lamps.reference_source_lamp <= ~ext_sel;
      o_lamps.base_clock_lamp <= (hb_alive | hb_edge) & brd_ff2.base_heartbeat;
      o_lamps.oscillator_failure_lamp <= brd_ff2.osc_lost;
      o_lamps.host_bus_up_lamp <= brd_ff2.link_up;
      o_lamps.setup_done_lamp <= setup_seen | brd_ff2.config_done;
      o_lamps.ident_lamp <= ctrl[CTRL_IDENT];
      o_lamps.power_fault_lamp <= brd_ff2.power_fault;
      o_ac_coupling <= ctrl[CTRL_AC_LO+:2];
      o_adc_sample_en <= sample_tick;
      o_record_sample <= sample_tick && capturing;
      o_record_end <= (state == RAC_POST) && post_done;
      unique case (spare_mode)
        RAC_SPARE_CAPTURE_EVENT_LAMP_OUT:
        begin
          o_spare_io_oe <= 1'b1;
          o_spare_io_out <= capture_event_lamp_take;
        end
        RAC_SPARE_PACER_OUT:
        begin
          o_spare_io_oe <= 1'b1;
          o_spare_io_out <= pacer_lvl;
        end
        RAC_SPARE_DIG_OUT:
        begin
          o_spare_io_oe <= 1'b1;
          o_spare_io_out <= spare_dout;
        end
        default:
        begin
          o_spare_io_oe <= 1'b0;
          o_spare_io_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: test/rac_top_chk.sv */
// Port checker for the record acquisition control block
`timescale 1ns/1ps
module rac_top_chk
  import rac_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [rac_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [rac_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire rac_pkg::rac_board_s i_board,
  input wire logic o_spare_io_oe,
  input wire logic [1:0] o_ac_coupling,
  input wire rac_pkg::rac_lamps_s o_lamps
);
  logic [2:0] since_rst;
  logic [31:0] wd_q;
  logic settled;
  logic wr_ok;
  // Pin lamps carry reset-time history for a few edges
  assign settled = (since_rst >= 3'h5);
  assign wr_ok = i_avs_write && !o_avs_waitrequest && (i_avs_byteenable == 4'hF);
  always_ff @(posedge i_sys_clk)
  begin
    since_rst <= !i_nrst ? 3'h0 : since_rst + {2'h0, since_rst != 3'h7};
    wd_q <= wr_ok ? i_avs_writedata : wd_q;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  a_base_lamp_live: assert property (settled && $past(i_board.base_heartbeat, 3)
    != $past(i_board.base_heartbeat, 4) |-> $changed(o_lamps.base_clock_lamp))
    else $error("base lamp stuck");
  a_osc_lamp_follows: assert property (settled |-> o_lamps.oscillator_failure_lamp
    == $past(i_board.osc_lost, 3)) else $error("oscillator lamp wrong");
  a_link_lamp_follows: assert property (settled |-> o_lamps.host_bus_up_lamp
    == $past(i_board.link_up, 3)) else $error("link lamp wrong");
  a_setup_lamp_sticky: assert property (o_lamps.setup_done_lamp
    |=> o_lamps.setup_done_lamp) else $error("setup lamp dropped");
  a_setup_lamp_cause: assert property (settled && $rose(o_lamps.setup_done_lamp)
    |-> $past(i_board.config_done, 3)) else $error("setup lamp early");
  a_power_lamp_follows: assert property (settled |-> o_lamps.power_fault_lamp
    == $past(i_board.power_fault, 3)) else $error("power lamp wrong");
  a_spare_dir_set: assert property (wr_ok && i_avs_address == REG_SPARE_IO
    |-> ##2 o_spare_io_oe == (wd_q[2:0] < 3'h3)) else $error("spare direction wrong");
  a_coupling_set: assert property (wr_ok && i_avs_address == REG_CTRL
    |-> ##2 o_ac_coupling == wd_q[7:6]) else $error("coupling wrong");
  a_ident_set: assert property (wr_ok && i_avs_address == REG_CTRL
    |-> ##2 o_lamps.ident_lamp == wd_q[8]) else $error("ident lamp wrong");
endmodule
bind rac_top rac_top_chk rac_top_chk_i (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_board(i_board), .o_spare_io_oe(o_spare_io_oe), .o_ac_coupling(o_ac_coupling),
  .o_lamps(o_lamps)
);

/* File: test/rac_far_model.sv */
// Far-side model: signal sources, outside clock and board supervision
`timescale 1ns/1ps
module rac_far_model
  import rac_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [1:0] i_fire,
  input wire rac_pkg::rac_board_s i_status,
  output logic o_ext_clk,
  output logic o_chan_one_capture_event_lamp,
  output logic o_chan_two_capture_event_lamp,
  output logic o_outside_event,
  output rac_pkg::rac_board_s o_board
);
  logic [3:0] hb_cnt = 4'h0;
  logic [2:0] hold = 3'h0;
  logic [1:0] src = 2'h0;
  // 5 MHz, free running, edges 8 ns before a system clock rising edge
  initial
  begin
    o_ext_clk = 1'h0;
    #17;
    forever #100 o_ext_clk = ~o_ext_clk;
  end
  // Pulse held 4 cycles so the synchroniser cannot miss it
  always @(posedge i_sys_clk)
  begin
    hb_cnt <= hb_cnt + 4'h1;
    if (i_fire != 2'h0)
    begin
      src <= i_fire;
      hold <= 3'h4;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign o_chan_one_capture_event_lamp = (hold != 3'h0) && (src == 2'h1);
  assign o_chan_two_capture_event_lamp = (hold != 3'h0) && (src == 2'h2);
  assign o_outside_event = (hold != 3'h0) && (src == 2'h3);
  // Slow heartbeat stands in for the divided base clock
  always_comb
  begin
    o_board = i_status;
    o_board.base_heartbeat = hb_cnt[3];
  end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the record acquisition control block
`timescale 1ns/1ps
module testbench;
  import rac_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic spare_in = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [1:0] fire = 2'h0;
  rac_board_s status = '0;
  logic [31:0] smp_cnt = 32'h0;
  logic [31:0] adc_cnt = 32'h0;
  logic [31:0] rdata, q, c0;
  logic wreq, ext_clk, t1, t2, tev, sp_out, sp_oe, adc_en, rec_smp, rec_end;
  logic [1:0] ac;
  rac_lamps_s lamps;
  rac_board_s board;
  int bad_count = 0;
  int checks = 0;
  int unsigned lens[7] = '{240, 264, 4096, 4096, 256, 4096, 4096};
  int unsigned pres[7] = '{0, 0, 4088, 2048, 0, 2032, 4080};
  int unsigned cnts[7] = '{1, 1, 1, 1, 0, 3, 1};
  logic [6:0] duals = 7'h28;
  logic [6:0] oks = 7'h60;

  rac_top rac_top_i (
    .i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_outside_sample_clock_input(ext_clk), .i_chan_one_capture_event_lamp(t1), .i_chan_two_capture_event_lamp(t2),
    .i_outside_event_input(tev), .i_spare_io_in(spare_in), .i_board(board),
    .o_spare_io_out(sp_out), .o_spare_io_oe(sp_oe), .o_adc_sample_en(adc_en),
    .o_record_sample(rec_smp), .o_record_end(rec_end), .o_ac_coupling(ac), .o_lamps(lamps)
  );
  rac_far_model rac_far_model_i (
    .i_sys_clk(clk), .i_fire(fire), .i_status(status), .o_ext_clk(ext_clk),
    .o_chan_one_capture_event_lamp(t1), .o_chan_two_capture_event_lamp(t2), .o_outside_event(tev), .o_board(board)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (rec_smp === 1'h1)
      smp_cnt <= smp_cnt + 32'h1;
  always @(posedge clk)
    if (adc_en === 1'h1)
      adc_cnt <= adc_cnt + 32'h1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'h0);
    r = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask
  task automatic rreg(input logic [7:0] a);
    bus(1'h0, a, 32'h0, q);
  endtask
  task automatic pulse(input logic [1:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 2'h0;
  endtask

  task automatic t_regs;
    rreg(REG_CTRL);
    chk(q[9:0], CTRL_RESET);
    rreg(REG_PACER_DIV);
    chk(q[15:0], PACER_DIV_RESET);
    rreg(REG_STATUS);
    chk(q[3:0], 4'h0);
    wreg(8'h20, 32'hFFFF);
    rreg(8'h20);
    chk(q, 32'h0);
    be <= 4'h3;
    wreg(REG_CTRL, 32'h1C0);
    be <= 4'hF;
    repeat (4) @(posedge clk);
    chk(ac, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 4; i++)
    begin
      wreg(REG_CTRL, 32'h4 | (i << 6) | ((i & 1) << 8) | ((i >> 1) << 3));
      repeat (4) @(posedge clk);
      chk(ac, i);
      chk(lamps.ident_lamp, i & 1);
      chk(lamps.reference_source_lamp, !(i >> 1));
    end
    wreg(REG_CTRL, 32'h4);
    $display("test ctrl done");
  endtask
  task automatic t_spare;
    for (int m = 0; m < 5; m++)
    begin
      wreg(REG_SPARE_IO, 32'h10 | m);
      if (m == 4)
        spare_in <= 1'h0;
      repeat (3) @(posedge clk);
      chk(sp_oe, m < 3);
      rreg(REG_SPARE_IO);
      if (m == 2)
        chk(sp_out, 1'h1);
      if (m == 4)
        chk(q[5], 1'h0);
    end
    spare_in <= 1'h1;
    $display("test spare done");
  endtask
  task automatic t_board;
    status <= 6'h3C;
    repeat (6) @(posedge clk);
    chk(lamps.oscillator_failure_lamp, 1'h1);
    chk(lamps.host_bus_up_lamp, 1'h1);
    chk(lamps.power_fault_lamp, 2'h2);
    status <= 6'h00;
    repeat (6) @(posedge clk);
    chk({lamps.oscillator_failure_lamp, lamps.power_fault_lamp}, 3'h0);
    chk(lamps.setup_done_lamp, 1'h1);
    $display("test board done");
  endtask
  task automatic t_bad;
    for (int i = 0; i < 7; i++)
    begin
      wreg(REG_REC_LEN, lens[i]);
      wreg(REG_PRETRIG, pres[i]);
      wreg(REG_REC_COUNT, cnts[i]);
      wreg(REG_CTRL, {29'h0, duals[i], 2'h1});
      rreg(REG_STATUS);
      chk(q[3:2], oks[i] ? 2'h1 : 2'h2);
      wreg(REG_CTRL, {22'h0, 1'h1, 6'h0, duals[i], 2'h2});
    end
    $display("test limits done");
  endtask
  task automatic t_acq;
    int n;
    wreg(REG_PACER_DIV, 32'h2);
    wreg(REG_REC_LEN, 32'h100);
    wreg(REG_PRETRIG, 32'h20);
    wreg(REG_REC_COUNT, 32'h2);
    wreg(REG_CTRL, 32'h20);
    wreg(REG_CTRL, 32'h21);
    for (int r = 0; r < 2; r++)
    begin
      c0 = smp_cnt;
      // Early trigger lands inside the pretrigger phase
      if (r == 0)
        pulse(2'h3);
      repeat (100) @(posedge clk);
      chk(lamps.capture_event_lamp, 1'h0);
      chk(lamps.armed_lamp, 1'h1);
      pulse(2'h3);
      repeat (20) @(posedge clk);
      chk(lamps.capture_event_lamp, 1'h1);
      n = 0;
      while (rec_end !== 1'h1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      #1;
      chk(smp_cnt - c0, 32'h100);
    end
    repeat (5) @(posedge clk);
    chk(lamps.armed_lamp, 1'h0);
    c0 = adc_cnt;
    repeat (100) @(posedge clk);
    chk(adc_cnt - c0, 32'h32);
    wreg(REG_CTRL, 32'h8);
    repeat (4) @(posedge clk);
    c0 = adc_cnt;
    repeat (200) @(posedge clk);
    chk(adc_cnt - c0, 32'h32);
    rreg(REG_RECS_DONE);
    chk(q, 32'h2);
    $display("test acquire done");
  endtask
  // Each channel as trigger source; the other channel is ignored
  task automatic t_chan;
    int n;
    wreg(REG_PRETRIG, 32'h0);
    wreg(REG_REC_COUNT, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      wreg(REG_CTRL, 32'h1 | (s << 4));
      pulse(2'(2 - s));
      repeat (10) @(posedge clk);
      chk(lamps.capture_event_lamp, 1'h0);
      pulse(2'(s + 1));
      repeat (10) @(posedge clk);
      chk(lamps.capture_event_lamp, 1'h1);
      n = 0;
      while (rec_end !== 1'h1 && n < 1000)
      begin
        @(posedge clk);
        n++;
      end
      repeat (3) @(posedge clk);
      chk(lamps.armed_lamp, 1'h0);
    end
    $display("test channels done");
  endtask

  task automatic end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    t_regs();
    t_ctrl();
    t_spare();
    t_board();
    t_bad();
    t_acq();
    t_chan();
    end_of_test();
  end
endmodule
